//--- common/fcsd_pkg.sv
package fcsd_pkg;
   // Flash command codes
   localparam logic [7:0] FCSD_CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] FCSD_CMD_IDENT = 8'h90;
   localparam logic [7:0] FCSD_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FCSD_CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] FCSD_CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] FCSD_CMD_PROG_SETUP_ALT = 8'h10;
   localparam logic [7:0] FCSD_CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] FCSD_CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] FCSD_CMD_ERASE_SUSPEND = 8'hb0;
   // Status word bit positions
   localparam int FCSD_SR_READY = 7;
   localparam int FCSD_SR_PAUSED = 6;
   localparam int FCSD_SR_ERASE_FAIL = 5;
   localparam int FCSD_SR_PROG_FAIL = 4;
   localparam int FCSD_SR_SUPPLY_LOW = 3;
   localparam logic [7:0] FCSD_SR_MEANING_MASK = 8'hf8;
   // Controller register offsets (word addresses on the local port)
   localparam logic [3:0] FCSD_REG_CTRL = 4'h0;
   localparam logic [3:0] FCSD_REG_ADDR = 4'h1;
   localparam logic [3:0] FCSD_REG_DATA = 4'h2;
   localparam logic [3:0] FCSD_REG_STATE = 4'h3;
   localparam logic [3:0] FCSD_REG_RESULT = 4'h4;
   localparam logic [3:0] FCSD_REG_IRQ_STAT = 4'h5;
   localparam logic [3:0] FCSD_REG_IRQ_MASK = 4'h6;
   localparam logic [3:0] FCSD_REG_IDENT = 4'h7;
   // Interrupt status bits
   localparam int FCSD_IRQ_DONE = 0;
   localparam int FCSD_IRQ_FAIL = 1;
   localparam int FCSD_IRQ_ERR = 2;
   // Bus cycle timing in ns and derived cycles at 125 MHz
   localparam int FCSD_CLK_NS = 8;
   localparam int FCSD_STROBE_NS = 80;
   localparam int FCSD_STROBE_CYC = (FCSD_STROBE_NS + FCSD_CLK_NS - 1) / FCSD_CLK_NS;
   localparam int FCSD_GAP_NS = 40;
   localparam int FCSD_GAP_CYC = (FCSD_GAP_NS + FCSD_CLK_NS - 1) / FCSD_CLK_NS;
   // Order codes written to the control register
   typedef enum logic [2:0]
   {
      FCSD_OP_NONE, FCSD_OP_READ, FCSD_OP_PROGRAM, FCSD_OP_ERASE,
      FCSD_OP_SUSPEND, FCSD_OP_RESUME, FCSD_OP_CLEAR, FCSD_OP_IDENT
   } fcsd_op_t;
endpackage

//--- sim/fcsd_flash_model.sv
`timescale 1ns/10ps
// Behavioural flash: command decoder, sequencer timed in 8 ns units, status word.
module fcsd_flash_model
   import fcsd_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'hc3 // Arbitrary value
)
(
   input wire logic i_ce_n, // Chip enable
   input wire logic i_oe_n, // Output enable
   input wire logic i_we_n, // Write enable
   input wire logic [16:0] i_addr, // Address pins
   input wire logic [15:0] i_dq, // Data pin level
   input wire logic [1:0] i_fault, // b0 operation fails, b1 supply low
   input wire logic [15:0] i_busy_cyc, // Operation length in clock periods
   output logic [15:0] o_dq, // Data driven to host
   output logic [16:0] o_prog_addr, // Last programmed location
   output logic [15:0] o_prog_val // Last programmed value
);
   typedef enum logic [1:0] {FCSD_M_ARRAY, FCSD_M_STATUS, FCSD_M_IDENT} fcsd_mode_t;
   fcsd_mode_t mode = FCSD_M_ARRAY;
   logic [7:0] cmd, snap = 8'h80;
   logic paused = 0, efail = 0, pfail = 0, vlow = 0, op_on = 0, op_erase = 0;
   logic pend_prog = 0, pend_erase = 0, wr_on = 0;
   logic [1:0] op_fault = 2'b00;
   logic [16:0] p_addr = '0;
   logic [15:0] p_val = 16'hffff, last = 16'h0000, rd_val;
   realtime t_end = 0, t_left = 0;
   assign o_prog_addr = p_addr;
   assign o_prog_val = p_val;
   task automatic start_op(input logic erase);
      op_on = 1'b1;
      op_erase = erase;
      op_fault = i_fault;
      mode = FCSD_M_STATUS;
      t_end = $realtime + i_busy_cyc * 8.0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // A write ends on whichever strobe rises first; both may rise in one time step
   always @(i_ce_n or i_we_n)
      if (!i_ce_n && !i_we_n)
         wr_on = 1'b1;
   always @(posedge i_we_n or posedge i_ce_n)
   begin
      if (wr_on)
      begin
         wr_on = 1'b0;
         cmd = i_dq[7:0];
         if (pend_prog)
         begin
            pend_prog = 1'b0;
            p_addr = i_addr;
            p_val = i_dq;
            start_op(1'b0);
         end
         else if (pend_erase)
         begin
            pend_erase = 1'b0;
            if (cmd == FCSD_CMD_ERASE_CONFIRM)
               start_op(1'b1);
            else
               {efail, pfail} = 2'b11;
            mode = FCSD_M_STATUS;
         end
         else if (op_on && !paused)
         begin
            if (cmd == FCSD_CMD_ERASE_SUSPEND && op_erase)
            begin
               paused = 1'b1;
               t_left = t_end - $realtime;
            end
            else if (cmd == FCSD_CMD_READ_STATUS)
               mode = FCSD_M_STATUS;
         end
         else
            case (cmd)
               FCSD_CMD_READ_ARRAY: mode = FCSD_M_ARRAY;
               FCSD_CMD_IDENT: mode = FCSD_M_IDENT;
               FCSD_CMD_READ_STATUS: mode = FCSD_M_STATUS;
               FCSD_CMD_CLEAR_STATUS: {efail, pfail, vlow} = 3'b000;
               FCSD_CMD_PROG_SETUP, FCSD_CMD_PROG_SETUP_ALT: pend_prog = 1'b1;
               FCSD_CMD_ERASE_SETUP: pend_erase = 1'b1;
               FCSD_CMD_ERASE_CONFIRM: if (paused)
               begin
                  paused = 1'b0;
                  t_end = $realtime + t_left;
               end
               default: ;
            endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Snapshot only on the later enable fall, so a poll needs a fresh strobe
   always @(negedge i_ce_n or negedge i_oe_n)
   begin
      if (!i_ce_n && !i_oe_n)
      begin
         if (op_on && !paused && $realtime >= t_end)
         begin
            op_on = 1'b0;
            efail = efail | (op_erase & op_fault[0]);
            pfail = pfail | (!op_erase & op_fault[0]);
            vlow = vlow | op_fault[1];
         end
         // Reserved bits carry noise on purpose
         snap = {!op_on || paused, paused, efail, pfail, vlow, 3'b101};
      end
   end
   assign rd_val = (mode == FCSD_M_STATUS) ? {8'h00, snap} :
                   (mode == FCSD_M_IDENT) ? {8'h00, i_addr[0] ? PART_ID : MAKER_ID} :
                   (i_addr == p_addr) ? p_val : 16'hffff;
   // Undriven bus shows the inverse of the last value, never a stale copy
   assign o_dq = (!i_ce_n && !i_oe_n) ? rd_val : ~last;
   always @(posedge i_oe_n)
      last = rd_val;
endmodule

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
   import fcsd_pkg::*;
   localparam logic [7:0] ID_MAKER = 8'h5a; // Arbitrary value
   localparam logic [7:0] ID_PART = 8'hc3; // Arbitrary value
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata, rv;
   logic o_irq, o_ce_n, o_oe_n, o_we_n, o_dq_oe;
   logic [16:0] o_fl_addr, prog_addr, a;
   logic [15:0] o_dq, flash_dq, dq_wire, prog_val, d;
   logic [1:0] fault = 2'b00;
   logic [15:0] busy_cyc = 16'h0010;
   logic ef = 1'b0, pf = 1'b0, vl = 1'b0, erase;
   int err_total = 0;
   int samples_checked = 0;
   integer seed = 50;
   assign dq_wire = o_dq_oe ? o_dq : flash_dq;
   fcsd_host #(.AW(17)) i_fcsd_host (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_fl_addr(o_fl_addr),
      .i_dq(dq_wire), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
   fcsd_flash_model #(.MAKER_ID(ID_MAKER), .PART_ID(ID_PART)) i_fcsd_flash_model (
      .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_fl_addr), .i_dq(dq_wire),
      .i_fault(fault), .i_busy_cyc(busy_cyc), .o_dq(flash_dq), .o_prog_addr(prog_addr),
      .o_prog_val(prog_val));
   initial
      forever #4 i_ref_clk = ~i_ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] dat);
      i_addr <= ad;
      i_wdata <= dat;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] ad, output logic [31:0] dat);
      i_addr <= ad;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      dat = o_rdata;
   endtask
   task automatic do_op(input fcsd_op_t op);
      int n;
      wr(FCSD_REG_CTRL, {29'h0, op});
      repeat (2) @(posedge i_ref_clk);
      for (n = 0; n < 4000; n++)
      begin
         rd(FCSD_REG_STATE, rv);
         if (rv[0] === 1'b0)
            break;
      end
      if (n == 4000)
      begin
         err_total++;
         $display("unexpected busy state: expected 0 seen 1");
         give_verdict();
      end
   endtask
   function automatic logic [31:0] exp_sr();
      return {24'h0, 1'b1, 1'b0, ef, pf, vl, 3'b000};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      @(posedge i_ref_clk);
      rd(FCSD_REG_IRQ_STAT, rv);
      chk("event bits after reset", rv, 32'h0);
      rd(4'hc, rv);
      chk("unmapped place", rv, 32'h0);
      chk("interrupt after reset", {31'h0, o_irq}, 32'h0);
      $display("test reset done");
      do_op(FCSD_OP_IDENT);
      rd(FCSD_REG_IDENT, rv);
      chk("identifier codes", rv, {16'h0, ID_PART, ID_MAKER});
      do_op(FCSD_OP_READ);
      $display("test identifier done");
      // Random program and erase series, both setup codes forced first
      wr(FCSD_REG_IRQ_MASK, 32'h7);
      for (int i = 0; i < 16; i++)
      begin
         rv = $random(seed);
         a = rv[30:14];
         d = (i < 2) ? {i[0], 15'h1234} : rv[15:0];
         erase = (i >= 2) && rv[0];
         rv = $random(seed);
         fault <= (i == 2) ? 2'b01 : {rv[5:3] == 3'b111, rv[2:1] == 2'b11};
         busy_cyc <= {10'h0, rv[13:8]};
         wr(FCSD_REG_ADDR, {15'h0, a});
         wr(FCSD_REG_DATA, {16'h0, d});
         do_op(erase ? FCSD_OP_ERASE : FCSD_OP_PROGRAM);
         ef = ef | (erase & fault[0]);
         pf = pf | (!erase & fault[0]);
         vl = vl | fault[1];
         rd(FCSD_REG_RESULT, rv);
         chk("status word", rv, exp_sr());
         if (!erase)
         begin
            chk("programmed location", {15'h0, prog_addr}, {15'h0, a});
            chk("programmed value", {16'h0, prog_val}, {16'h0, d});
         end
         rd(FCSD_REG_IRQ_STAT, rv);
         chk("event bits", rv, {30'h0, ef | pf | vl, 1'b1});
         chk("interrupt raised", {31'h0, o_irq}, 32'h1);
         wr(FCSD_REG_IRQ_STAT, 32'h7);
         rd(FCSD_REG_IRQ_STAT, rv);
         chk("event bits cleared", rv, 32'h0);
         chk("interrupt dropped", {31'h0, o_irq}, 32'h0);
         if (i % 4 == 3)
         begin
            do_op(FCSD_OP_CLEAR);
            {ef, pf, vl} = 3'b000;
            wr(FCSD_REG_IRQ_STAT, 32'h7);
         end
      end
      $display("test program and erase series done");
      // Order other than suspend written while an erase runs must be refused
      do_op(FCSD_OP_CLEAR);
      {ef, pf, vl} = 3'b000;
      fault <= 2'b00;
      busy_cyc <= 16'd2000;
      wr(FCSD_REG_IRQ_MASK, 32'h0);
      wr(FCSD_REG_CTRL, {29'h0, FCSD_OP_ERASE});
      repeat (60) @(posedge i_ref_clk);
      wr(FCSD_REG_CTRL, {29'h0, FCSD_OP_CLEAR});
      wr(FCSD_REG_CTRL, {29'h0, FCSD_OP_SUSPEND});
      do_op(FCSD_OP_NONE);
      rd(FCSD_REG_RESULT, rv);
      chk("status while paused", rv, exp_sr() | 32'h40);
      do_op(FCSD_OP_RESUME);
      rd(FCSD_REG_RESULT, rv);
      chk("status after resume", rv, exp_sr());
      rd(FCSD_REG_IRQ_STAT, rv);
      chk("refused order bit", rv & 32'h4, 32'h4);
      chk("masked interrupt", {31'h0, o_irq}, 32'h0);
      wr(FCSD_REG_IRQ_MASK, 32'h4);
      #1;
      chk("unmasked interrupt", {31'h0, o_irq}, 32'h1);
      wr(FCSD_REG_IRQ_STAT, 32'h4);
      #1;
      chk("interrupt after clear", {31'h0, o_irq}, 32'h0);
      $display("test refusal and interrupt done");
      busy_cyc <= 16'h0004;
      do_op(FCSD_OP_SUSPEND);
      do_op(FCSD_OP_RESUME);
      rd(FCSD_REG_RESULT, rv);
      chk("status after idle suspend", rv, exp_sr());
      do_op(FCSD_OP_READ);
      $display("test idle suspend done");
      give_verdict();
   end
endmodule

//--- src/fcsd_bus_cycle.sv
`timescale 1ns/10ps
// One flash bus cycle: enable low for a fixed time, then a gap.
module fcsd_bus_cycle
   import fcsd_pkg::*;
#(
   parameter int STROBE_CYC = FCSD_STROBE_CYC,
   parameter int GAP_CYC = FCSD_GAP_CYC
)
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_srst, // Sync reset
   input wire logic i_start, // Start a cycle, pulse
   input wire logic i_write, // 1 write, 0 read
   input wire logic [15:0] i_dq_in, // Data pins in
   output logic o_busy, // Cycle under way
   output logic o_done, // Cycle finished, pulse
   output logic o_ce_n, // Chip enable
   output logic o_oe_n, // Output enable
   output logic o_we_n, // Write enable
   output logic o_dq_oe, // Host drives data pins
   output logic [7:0] o_rdata // Low byte captured on read
);
   localparam int CW = $clog2(STROBE_CYC + GAP_CYC + 1);
   localparam logic [CW-1:0] LAST_STROBE = CW'(STROBE_CYC - 1);
   localparam logic [CW-1:0] LAST_ALL = CW'(STROBE_CYC + GAP_CYC - 1);
   logic [CW-1:0] cnt_r;
   logic busy_r;
   logic wr_r;
   logic [7:0] rdata_r;
   wire in_strobe = busy_r && (cnt_r <= LAST_STROBE);
   wire sample = busy_r && !wr_r && (cnt_r == LAST_STROBE);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         wr_r <= 1'b0;
      end
      else if (i_start && !busy_r)
      begin
         busy_r <= 1'b1;
         cnt_r <= '0;
         wr_r <= i_write;
      end
      else if (busy_r)
      begin
         busy_r <= (cnt_r != LAST_ALL);
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // Sampled late in the strobe so the device has settled its output
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         rdata_r <= 8'h00;
      else if (sample)
         rdata_r <= i_dq_in[7:0];
   end

   // Both enables fall together each read, so a new status latch happens
   assign o_ce_n = !in_strobe;
   assign o_oe_n = !(in_strobe && !wr_r);
   assign o_we_n = !(in_strobe && wr_r);
   assign o_dq_oe = busy_r && wr_r;
   assign o_busy = busy_r;
   assign o_done = busy_r && (cnt_r == LAST_ALL);
   assign o_rdata = rdata_r;

   strobe_len_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      $fell(o_ce_n) |-> !o_ce_n [*2] ##(STROBE_CYC - 1) o_ce_n)
      else $error("enable pulse length wrong");
   no_drive_read_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      !o_oe_n |-> !o_dq_oe)
      else $error("host drives data during read");
endmodule

//--- src/fcsd_host.sv
`timescale 1ns/10ps
// Controller that drives the flash through its pins; software orders via a local port.
module fcsd_host
   import fcsd_pkg::*;
#(
   parameter int AW = 17
)
(
   input wire logic i_ref_clk, // Clock, 125 MHz
   input wire logic i_srst, // Sync reset, high
   input wire logic [3:0] i_addr, // Register word address
   input wire logic [31:0] i_wdata, // Write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [31:0] o_rdata, // Read data, cycle after strobe
   output logic o_irq, // Level interrupt
   output logic o_ce_n, // Flash chip enable
   output logic o_oe_n, // Flash output enable
   output logic o_we_n, // Flash write enable
   output logic [AW-1:0] o_fl_addr, // Flash address
   input wire logic [15:0] i_dq, // Flash data in
   output logic [15:0] o_dq, // Flash data out
   output logic o_dq_oe // Flash data drive enable
);
   typedef enum logic [2:0] {FCSD_IDLE, FCSD_CMD, FCSD_SECOND, FCSD_POLL, FCSD_ID1, FCSD_ID2}
      fcsd_state_t;

   function automatic logic status_done(input logic [7:0] s);
      status_done = s[FCSD_SR_READY];
   endfunction

   ////////////////////////////////////////////////////////////////
   fcsd_state_t state_r, state_nxt;
   fcsd_op_t op_r;
   logic [AW-1:0] addr_r;
   logic [15:0] data_r;
   logic [7:0] status_r;
   logic [7:0] maker_r;
   logic [7:0] part_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [31:0] rdata_r;
   logic [15:0] dq_r;
   logic [AW-1:0] fl_addr_r;
   logic cyc_start_r;
   logic cyc_write_r;
   logic susp_pend_r;
   logic cyc_busy;
   logic cyc_done;
   logic [7:0] cyc_rdata;

   wire wr_ctrl = i_wr && (i_addr == FCSD_REG_CTRL);
   wire wr_addr = i_wr && (i_addr == FCSD_REG_ADDR);
   wire wr_data = i_wr && (i_addr == FCSD_REG_DATA);
   wire wr_istat = i_wr && (i_addr == FCSD_REG_IRQ_STAT);
   wire wr_imask = i_wr && (i_addr == FCSD_REG_IRQ_MASK);
   wire idle = (state_r == FCSD_IDLE) && !cyc_busy && !cyc_start_r;
   wire fcsd_op_t new_op = fcsd_op_t'(i_wdata[2:0]);
   wire accept = wr_ctrl && idle && (new_op != FCSD_OP_NONE);
   // Only a suspend may break into the wait for an erase; anything else is refused
   wire susp_req = wr_ctrl && (new_op == FCSD_OP_SUSPEND) && (state_r == FCSD_POLL)
      && (op_r == FCSD_OP_ERASE) && !poll_done;
   // Mask reserved bits before judging the status word
   wire [7:0] status_meaning = cyc_rdata & FCSD_SR_MEANING_MASK;
   wire poll_done = (state_r == FCSD_POLL) && cyc_done && status_done(status_meaning);
   // Fail bits only trusted once ready reads one
   wire poll_fail = poll_done &&
      (status_meaning[FCSD_SR_ERASE_FAIL] || status_meaning[FCSD_SR_PROG_FAIL]
       || status_meaning[FCSD_SR_SUPPLY_LOW]);
   wire [2:0] irq_set = {wr_ctrl && !idle && !susp_req, poll_fail, poll_done};

   ////////////////////////////////////////////////////////////////
   // First command byte for each order
   logic [7:0] first_code;
   always_comb
   begin
      case (op_r)
         FCSD_OP_READ: first_code = FCSD_CMD_READ_ARRAY;
         FCSD_OP_PROGRAM: first_code = data_r[15] ? FCSD_CMD_PROG_SETUP_ALT
                                                  : FCSD_CMD_PROG_SETUP;
         FCSD_OP_ERASE: first_code = FCSD_CMD_ERASE_SETUP;
         FCSD_OP_SUSPEND: first_code = FCSD_CMD_ERASE_SUSPEND;
         FCSD_OP_RESUME: first_code = FCSD_CMD_ERASE_CONFIRM;
         FCSD_OP_CLEAR: first_code = FCSD_CMD_CLEAR_STATUS;
         FCSD_OP_IDENT: first_code = FCSD_CMD_IDENT;
         default: first_code = FCSD_CMD_READ_STATUS;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         FCSD_IDLE: if (accept) state_nxt = FCSD_CMD;
         FCSD_CMD:
            if (cyc_done)
            begin
               case (op_r)
                  FCSD_OP_PROGRAM, FCSD_OP_ERASE: state_nxt = FCSD_SECOND;
                  FCSD_OP_SUSPEND, FCSD_OP_RESUME: state_nxt = FCSD_POLL;
                  FCSD_OP_IDENT: state_nxt = FCSD_ID1;
                  default: state_nxt = FCSD_IDLE;
               endcase
            end
         FCSD_SECOND: if (cyc_done) state_nxt = FCSD_POLL;
         // Keep reading; each read is a fresh enable fall
         // A suspend taken mid-poll goes out once the read under way ends
         FCSD_POLL:
            if (cyc_done && susp_pend_r)
               state_nxt = FCSD_CMD;
            else if (poll_done)
               state_nxt = FCSD_IDLE;
         FCSD_ID1: if (cyc_done) state_nxt = FCSD_ID2;
         FCSD_ID2: if (cyc_done) state_nxt = FCSD_IDLE;
         default: state_nxt = FCSD_IDLE;
      endcase
   end

   // A new bus cycle starts each time a step needs one
   wire step_start = !cyc_busy && !cyc_start_r && (state_r != FCSD_IDLE);
   wire step_write = (state_r == FCSD_CMD) || (state_r == FCSD_SECOND);
   // Upper byte driven to zero on commands, never floating
   wire [15:0] step_dq = (state_r == FCSD_SECOND) ?
      ((op_r == FCSD_OP_ERASE) ? {8'h00, FCSD_CMD_ERASE_CONFIRM} : data_r)
      : {8'h00, first_code};
   // Identifier reads pick the code with the lowest address bit
   wire [AW-1:0] step_addr = (state_r == FCSD_ID1) ? {AW{1'b0}} :
      (state_r == FCSD_ID2) ? {{(AW-1){1'b0}}, 1'b1} : addr_r;

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         state_r <= FCSD_IDLE;
         op_r <= FCSD_OP_NONE;
         susp_pend_r <= 1'b0;
         cyc_start_r <= 1'b0;
         cyc_write_r <= 1'b0;
         dq_r <= 16'h0000;
         fl_addr_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (accept || susp_req)
            op_r <= new_op;
         if (susp_req)
            susp_pend_r <= 1'b1;
         else if (state_r != FCSD_POLL)
            susp_pend_r <= 1'b0;
         cyc_start_r <= step_start;
         if (step_start)
         begin
            cyc_write_r <= step_write;
            dq_r <= step_dq;
            fl_addr_r <= step_addr;
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         addr_r <= '0;
         data_r <= 16'h0000;
         irq_mask_r <= 3'h0;
      end
      else
      begin
         if (wr_addr && idle)
            addr_r <= i_wdata[AW-1:0];
         if (wr_data && idle)
            data_r <= i_wdata[15:0];
         if (wr_imask)
            irq_mask_r <= i_wdata[2:0];
      end
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         irq_stat_r <= 3'h0;
      else
         irq_stat_r <= (irq_stat_r & ~(wr_istat ? i_wdata[2:0] : 3'h0)) | irq_set;
   end

   // Last status kept; device flags accumulate until a clear order
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         status_r <= 8'h00;
         maker_r <= 8'h00;
         part_r <= 8'h00;
      end
      else if (cyc_done)
      begin
         if (state_r == FCSD_POLL)
            status_r <= status_meaning;
         if (state_r == FCSD_ID1)
            maker_r <= cyc_rdata;
         if (state_r == FCSD_ID2)
            part_r <= cyc_rdata;
      end
   end

   wire [31:0] rd_mux =
      (i_addr == FCSD_REG_CTRL) ? {29'h0, op_r} :
      (i_addr == FCSD_REG_ADDR) ? 32'(addr_r) :
      (i_addr == FCSD_REG_DATA) ? {16'h0, data_r} :
      (i_addr == FCSD_REG_STATE) ? {31'h0, !idle} :
      (i_addr == FCSD_REG_RESULT) ? {24'h0, status_r} :
      (i_addr == FCSD_REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
      (i_addr == FCSD_REG_IRQ_MASK) ? {29'h0, irq_mask_r} :
      (i_addr == FCSD_REG_IDENT) ? {16'h0, part_r, maker_r} : 32'h0;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         rdata_r <= 32'h0;
      else
         rdata_r <= i_rd ? rd_mux : 32'h0;
   end

   fcsd_bus_cycle u_cycle
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_start(cyc_start_r),
      .i_write(cyc_write_r),
      .i_dq_in(i_dq),
      .o_busy(cyc_busy),
      .o_done(cyc_done),
      .o_ce_n(o_ce_n),
      .o_oe_n(o_oe_n),
      .o_we_n(o_we_n),
      .o_dq_oe(o_dq_oe),
      .o_rdata(cyc_rdata)
   );

   assign o_dq = dq_r;
   assign o_fl_addr = fl_addr_r;
   assign o_rdata = rdata_r;
   assign o_irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////
   ident_two_reads_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_ID1 && cyc_done) |=> state_r == FCSD_ID2)
      else $error("identifier needs a second read");
   ident_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_ID2 && !o_oe_n) |-> o_fl_addr[0])
      else $error("part code read without lowest bit");
   upper_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_CMD && o_dq_oe) |-> o_dq[15:8] == 8'h00)
      else $error("upper byte not driven low on command");
   prog_setup_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_CMD && op_r == FCSD_OP_PROGRAM && !o_we_n)
      |-> (o_dq[7:0] == 8'h40 || o_dq[7:0] == 8'h10))
      else $error("bad program setup code");
   second_write_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_SECOND && op_r == FCSD_OP_PROGRAM && !o_we_n)
      |-> (o_dq == data_r && o_fl_addr == addr_r))
      else $error("program value or target wrong");
   erase_confirm_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_SECOND && op_r == FCSD_OP_ERASE && !o_we_n)
      |-> (o_dq[7:0] == 8'hd0 && o_fl_addr == addr_r))
      else $error("erase confirm wrong");
   poll_ready_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_POLL && cyc_done && !cyc_rdata[FCSD_SR_READY] && !susp_pend_r)
      |=> state_r == FCSD_POLL)
      else $error("poll left before ready");
   poll_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (state_r == FCSD_POLL && $fell(o_oe_n)) |-> $past(o_ce_n))
      else $error("status read without enable toggle");
   event_set_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      irq_set != 3'h0 |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
      else $error("event lost to a clear");

   cov_program_c: cover property (@(posedge i_ref_clk)
      state_r == FCSD_POLL && op_r == FCSD_OP_PROGRAM && poll_done);
   cov_erase_fail_c: cover property (@(posedge i_ref_clk)
      poll_done && status_meaning[FCSD_SR_ERASE_FAIL]);
   cov_suspend_c: cover property (@(posedge i_ref_clk)
      poll_done && status_meaning[FCSD_SR_PAUSED]);
   cov_ident_c: cover property (@(posedge i_ref_clk)
      state_r == FCSD_ID2 && cyc_done);
endmodule
